// ---- shared/sld_map.vh ----
// Register map, field positions, reset values and timing counts of the segment LCD controller
`ifndef SLD_MAP_VH
`define SLD_MAP_VH
`define SLD_ADDR_LCD_CONTROL      8'h00
`define SLD_ADDR_SEGMENT_PIN_SEL  8'h01
`define SLD_ADDR_CONTROL_REG_ZERO 8'h02
`define SLD_ADDR_MEM_BASE         8'h40
`define SLD_ADDR_MEM_LAST         8'h5b
`define SLD_LCD_CONTROL_POWER_DOWN_BIT   7
`define SLD_LCD_CONTROL_VA_SEL_BIT       6
`define SLD_LCD_CONTROL_BIAS_TYPE_BIT    4
`define SLD_LCD_CONTROL_CSS_HI           2
`define SLD_LCD_CONTROL_CSS_LO           0
`define SLD_LCD_CONTROL_WRITE_MASK       8'hd7
`define SLD_LCD_CONTROL_RESET            8'h00
`define SLD_PINSEL_RESET          8'h00
`define SLD_CONTROL_REG_ZERO_DIV_HI          1
`define SLD_CONTROL_REG_ZERO_DIV_LO          0
`define SLD_CONTROL_REG_ZERO_SRC_BIT         2
`define SLD_CONTROL_REG_ZERO_KEEP_BIT        3
`define SLD_CONTROL_REG_ZERO_WRITE_MASK      8'h0f
`define SLD_CONTROL_REG_ZERO_RESET           8'h00
`define SLD_DIV_CODE_3            2'h0
`define SLD_DIV_CODE_4            2'h1
`define SLD_FSUB_DIV_3            3'h3
`define SLD_FSUB_DIV_4            3'h4
`define SLD_FSUB_DIV_8            4'h8
`define SLD_MEM_WORDS             28
`define SLD_LVL_VSS               2'h0
`define SLD_LVL_THIRD             2'h1
`define SLD_LVL_TWO_THIRD         2'h2
`define SLD_LVL_FULL              2'h3
`endif

// ---- hdl/sld_clk_div.v ----
// Sub clock edge detector and divide-by-3/4/8 LCD tick generator
`timescale 1ns/100ps
`include "sld_map.vh"
module sld_clk_div
(
  // System
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       ce_i,
  // Sub clock and control
  input  wire       sub_clk_i,
  input  wire [1:0] div_sel_i,
  // Tick out
  output wire       tick_o
);
  reg       sync1_reg;
  reg       sync2_reg;
  reg       last_reg;
  reg [2:0] cnt_reg;
  reg [2:0] cnt_next;
  reg       tick_reg;
  reg       tick_next;
  reg [3:0] cnt_inc;
  wire      sub_rise;
  wire [3:0] div_val;

  // Count kept in three bits; the compare needs a fourth for the /8 limit
  assign div_val  = (div_sel_i == `SLD_DIV_CODE_3) ? {1'b0, `SLD_FSUB_DIV_3} :
                    (div_sel_i == `SLD_DIV_CODE_4) ? {1'b0, `SLD_FSUB_DIV_4} : `SLD_FSUB_DIV_8;
  assign sub_rise = sync2_reg & ~last_reg;
  assign tick_o   = tick_reg;

  always @*
  begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    cnt_inc   = {1'b0, cnt_reg} + 4'h1;
    if (sub_rise)
    begin
      if (cnt_inc == div_val)
      begin
        cnt_next  = 3'h0;
        tick_next = 1'b1;
      end
      else
        cnt_next = cnt_inc[2:0];
    end
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
      cnt_reg   <= 3'h0;
      tick_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_reg <= sub_clk_i;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
      cnt_reg   <= cnt_next;
      tick_reg  <= tick_next;
    end
  end
endmodule // sld_clk_div

// ---- hdl/sld_lcd_ctrl.v ----
// Segment LCD controller: registers, display memory and multiplexed 1/3 bias drive
// Operation
// - Power-down bit 1 disables drive, resets 0
// - VA select: 0 regulator, 1 one-and-half; code gives one-and-half only with bias type 1
// - Bias type: 0 resistor, 1 charge pump
// - Common/segment field sets duty, pin roles
// - Unimplemented control bits read zero, ignore writes
// - Pin select bit: 0 GPIO, 1 segment
// - LCD clock is sub clock /3,/4,/8
// - Source bit picks RC or crystal
// - Keep bit runs sub clock in power-down
// - Always one-third bias, any duty
// - Alternating polarity, zero DC, slots per common
// - R type levels ground, third, two-thirds, full
// - C type enables fixed-ratio charge pump
// - Power-down LCD operation fixed by strap
// - Memory continuously scanned onto panel
// - Display memory at 40h through 5bh
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "sld_map.vh"
module sld_lcd_ctrl
(
  // System
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        ce_i,
  // Register port
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output wire [7:0]  rdata_o,
  // Clocks and power state
  input  wire        low_speed_rc_osc_clk_i,
  input  wire        lxt_clk_i,
  input  wire        powerdown_i,
  input  wire        opt_pd_lcd_on_i,
  // Analog controls
  output wire        charge_pump_en_o,
  output wire        va_one_half_o,
  output wire        bias_r_type_o,
  output wire        sub_clk_run_o,
  // Panel drive levels, two bits per pin, and segment pin routing, one bit per pin
  output wire [15:0] com_lvl_o,
  output wire [55:0] seg_lvl_o,
  output wire [7:0]  seg_pin_is_lcd_o
);
  ////////////////////////////////////////////////////////////////////////
  reg  [7:0] lcd_control_reg;
  reg  [7:0] pinsel_reg;
  reg  [7:0] control_reg_zero_reg;
  reg  [7:0] rdata_reg;
  reg  [7:0] rdata_next;
  reg  [7:0] mem_reg [0:`SLD_MEM_WORDS-1];
  reg        strap_reg;
  reg        strap_sync_reg;
  reg        sync1_reg;
  reg        pd_reg;
  reg  [2:0] slot_reg;
  reg        phase_reg;
  reg  [15:0] com_reg;
  reg  [55:0] seg_reg;
  reg  [15:0] com_next;
  reg  [55:0] seg_next;
  reg  [2:0] num_com;
  wire       lcd_tick;
  wire       sub_clk;
  wire       drive_on;
  wire [2:0] css;
  integer    i;
  integer    c;

  // Register decode codes
  localparam SEL_NONE = 2'h0;
  localparam SEL_LCD_CONTROL = 2'h1;
  localparam SEL_PINS = 2'h2;
  localparam SEL_CTRL = 2'h3;

  // One decoder shared by the read and the write path
  function [1:0] reg_sel;
    input [7:0] a;
    begin
      if (a == `SLD_ADDR_LCD_CONTROL)
        reg_sel = SEL_LCD_CONTROL;
      else if (a == `SLD_ADDR_SEGMENT_PIN_SEL)
        reg_sel = SEL_PINS;
      else if (a == `SLD_ADDR_CONTROL_REG_ZERO)
        reg_sel = SEL_CTRL;
      else
        reg_sel = SEL_NONE;
    end
  endfunction

  // Level for the current half of the AC cycle
  function [1:0] by_phase;
    input       ph;
    input [1:0] lvl0;
    input [1:0] lvl1;
    begin
      by_phase = ph ? lvl1 : lvl0;
    end
  endfunction

  function in_mem;
    input [7:0] a;
    begin
      in_mem = (a >= `SLD_ADDR_MEM_BASE) && (a <= `SLD_ADDR_MEM_LAST);
    end
  endfunction

  function [4:0] mem_idx;
    input [7:0] a;
    reg   [7:0] d;
    begin
      d       = a - `SLD_ADDR_MEM_BASE;
      mem_idx = d[4:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign css      = lcd_control_reg[`SLD_LCD_CONTROL_CSS_HI:`SLD_LCD_CONTROL_CSS_LO];
  // Strap is resampled through two flops on every enabled cycle; software has no path to it
  assign drive_on = ~lcd_control_reg[`SLD_LCD_CONTROL_POWER_DOWN_BIT] & (~pd_reg | strap_reg);
  // Raw clock mux: a source switch may stretch or shorten one slot, nothing worse
  assign sub_clk  = control_reg_zero_reg[`SLD_CONTROL_REG_ZERO_SRC_BIT] ? lxt_clk_i : low_speed_rc_osc_clk_i;
  assign sub_clk_run_o    = ~pd_reg | control_reg_zero_reg[`SLD_CONTROL_REG_ZERO_KEEP_BIT];
  assign charge_pump_en_o = lcd_control_reg[`SLD_LCD_CONTROL_BIAS_TYPE_BIT] & drive_on;
  assign bias_r_type_o    = ~lcd_control_reg[`SLD_LCD_CONTROL_BIAS_TYPE_BIT];
  assign va_one_half_o    = lcd_control_reg[`SLD_LCD_CONTROL_VA_SEL_BIT] & lcd_control_reg[`SLD_LCD_CONTROL_BIAS_TYPE_BIT];
  assign seg_pin_is_lcd_o = pinsel_reg;
  assign rdata_o          = rdata_reg;
  assign com_lvl_o        = com_reg;
  assign seg_lvl_o        = seg_reg;

  always @*
  begin
    // Commons = 4 + css, saturating at 8 for any 1xx code
    if (css[2])
      num_com = 3'h7;
    else
      num_com = 3'h3 + {1'b0, css[1:0]};
  end

  sld_clk_div u_div
  (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .sub_clk_i (sub_clk),
    .div_sel_i (control_reg_zero_reg[`SLD_CONTROL_REG_ZERO_DIV_HI:`SLD_CONTROL_REG_ZERO_DIV_LO]),
    .tick_o    (lcd_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register port
  always @*
  begin
    rdata_next = 8'h00;
    if (rd_i)
    begin
      if (reg_sel(addr_i) == SEL_LCD_CONTROL)
        rdata_next = lcd_control_reg & `SLD_LCD_CONTROL_WRITE_MASK;
      else if (reg_sel(addr_i) == SEL_PINS)
        rdata_next = pinsel_reg;
      else if (reg_sel(addr_i) == SEL_CTRL)
        rdata_next = control_reg_zero_reg;
      else if (in_mem(addr_i))
        rdata_next = mem_reg[mem_idx(addr_i)];
      else
        rdata_next = 8'h00;
    end
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      lcd_control_reg   <= `SLD_LCD_CONTROL_RESET;
      pinsel_reg <= `SLD_PINSEL_RESET;
      control_reg_zero_reg  <= `SLD_CONTROL_REG_ZERO_RESET;
      rdata_reg  <= 8'h00;
    end
    else if (ce_i)
    begin
      rdata_reg <= rdata_next;
      if (wr_i)
      begin
        if (reg_sel(addr_i) == SEL_LCD_CONTROL)
          lcd_control_reg <= wdata_i & `SLD_LCD_CONTROL_WRITE_MASK;
        else if (reg_sel(addr_i) == SEL_PINS)
          pinsel_reg <= wdata_i;
        else if (reg_sel(addr_i) == SEL_CTRL)
          control_reg_zero_reg <= wdata_i & `SLD_CONTROL_REG_ZERO_WRITE_MASK;
      end
    end
  end

  // Display memory has no reset: contents undefined until software fills it
  always @(posedge clk_i)
  begin
    if (ce_i && wr_i && in_mem(addr_i))
      mem_reg[mem_idx(addr_i)] <= wdata_i;
  end

  // Power-down pin crossing and strap capture
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync1_reg      <= 1'b0;
      pd_reg         <= 1'b0;
      strap_sync_reg <= 1'b0;
      strap_reg      <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_reg      <= powerdown_i;
      pd_reg         <= sync1_reg;
      strap_sync_reg <= opt_pd_lcd_on_i;
      strap_reg      <= strap_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer: one slot per common, polarity flips each frame
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      slot_reg  <= 3'h0;
      phase_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!drive_on)
      begin
        slot_reg  <= 3'h0;
        phase_reg <= 1'b0;
      end
      else if (lcd_tick)
      begin
        if (slot_reg >= num_com)
        begin
          slot_reg  <= 3'h0;
          phase_reg <= ~phase_reg;
        end
        else
          slot_reg <= slot_reg + 3'h1;
      end
    end
  end

  // Levels at 1/3 bias: selected com full/ground, idle com third/two-thirds;
  // segments take the opposite extreme or the other inner level.
  always @*
  begin
    com_next = {8{`SLD_LVL_VSS}};
    seg_next = {28{`SLD_LVL_VSS}};
    if (drive_on)
    begin
      for (c = 0; c < 8; c = c + 1)
      begin
        if (c > num_com)
          com_next[2*c +: 2] = `SLD_LVL_VSS;
        else if (c == slot_reg)
          com_next[2*c +: 2] = by_phase(phase_reg, `SLD_LVL_FULL, `SLD_LVL_VSS);
        else
          com_next[2*c +: 2] = by_phase(phase_reg, `SLD_LVL_THIRD, `SLD_LVL_TWO_THIRD);
      end
      for (i = 0; i < `SLD_MEM_WORDS; i = i + 1)
      begin
        if (mem_reg[i][slot_reg])
          seg_next[2*i +: 2] = by_phase(phase_reg, `SLD_LVL_VSS, `SLD_LVL_FULL);
        else
          seg_next[2*i +: 2] = by_phase(phase_reg, `SLD_LVL_TWO_THIRD, `SLD_LVL_THIRD);
      end
      // Shared pins 27..24 become commons 4..7; keep them off segment drive
      for (i = 0; i < 4; i = i + 1)
      begin
        if (i + 4 <= num_com)
          seg_next[2*(27-i) +: 2] = `SLD_LVL_VSS;
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      com_reg <= 16'h0000;
      seg_reg <= 56'h00000000000000;
    end
    else if (ce_i)
    begin
      com_reg <= com_next;
      seg_reg <= seg_next;
    end
  end
endmodule // sld_lcd_ctrl

// ---- sim/sld_lcd_checker.sv ----
// Assertions on the segment LCD controller ports
`timescale 1ns/100ps
module sld_lcd_checker
(
  // Register port
  input wire        clk_i,
  input wire        srst_i,
  input wire        ce_i,
  input wire [7:0]  addr_i,
  input wire [7:0]  wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [7:0]  rdata_o,
  // Controls and drive
  input wire        charge_pump_en_o,
  input wire        va_one_half_o,
  input wire        bias_r_type_o,
  input wire [15:0] com_lvl_o,
  input wire [55:0] seg_lvl_o,
  input wire [7:0]  seg_pin_is_lcd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Control byte read back stands one cycle after the read
  wire rd_ctl = ce_i && rd_i && addr_i == 8'h00;
  property p_rsv; rd_ctl |=> rdata_o[5] == 1'b0 && rdata_o[3] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_bias; rd_ctl |=> bias_r_type_o == !rdata_o[4]; endproperty
  a_bias: assert property (p_bias) else $error("bias type mismatch");
  property p_va; rd_ctl |=> va_one_half_o == (rdata_o[6] && rdata_o[4]); endproperty
  a_va: assert property (p_va) else $error("va level mismatch");
  property p_pump; rd_ctl |=> !charge_pump_en_o || (rdata_o[4] && !rdata_o[7]); endproperty
  a_pump: assert property (p_pump) else $error("pump on wrongly");
  property p_pins; ce_i && rd_i && addr_i == 8'h01 |=> seg_pin_is_lcd_o == rdata_o; endproperty
  a_pins: assert property (p_pins) else $error("pin routing mismatch");
  property p_off;
    ce_i && wr_i && addr_i == 8'h00 && wdata_i[7] |=> ##2 com_lvl_o == 16'h0 && seg_lvl_o == 56'h0;
  endproperty
  a_off: assert property (p_off) else $error("drive not off");
  property p_sel; !(com_lvl_o[1:0] == 2'h3 && com_lvl_o[3:2] == 2'h3); endproperty
  a_sel: assert property (p_sel) else $error("two commons selected");
  property p_lvl; com_lvl_o[1:0] == 2'h3 |-> seg_lvl_o[0] == 1'b0; endproperty
  a_lvl: assert property (p_lvl) else $error("segment level outside phase");
  c_off: cover property (wr_i && wdata_i[7]);
  c_c7: cover property (com_lvl_o[15:14] == 2'h3);
  c_ph: cover property (com_lvl_o[1:0] == 2'h0 && com_lvl_o[3:2] == 2'h2);
endmodule // sld_lcd_checker
////////////////////////////////////////////////////////////////////////////////
bind sld_lcd_ctrl sld_lcd_checker chk
(
  .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .charge_pump_en_o(charge_pump_en_o), .va_one_half_o(va_one_half_o),
  .bias_r_type_o(bias_r_type_o), .com_lvl_o(com_lvl_o), .seg_lvl_o(seg_lvl_o), .seg_pin_is_lcd_o(seg_pin_is_lcd_o)
);

// ---- sim/sld_glass_model.sv ----
// Glass model: pixels seen in the positive phase, slot length and phase flips
`timescale 1ns/100ps
module sld_glass_model
(
  // Drive levels
  input  wire         clk_i,
  input  wire [15:0]  com_lvl_i,
  input  wire [55:0]  seg_lvl_i,
  // Observations
  output reg  [223:0] pix_o = 224'h0,
  output reg  [15:0]  slot_len_o = 16'h0,
  output reg  [15:0]  flips_o = 16'h0
);
  reg [15:0] run = 16'h0;
  reg        neg = 1'b0;
  integer    c;
  integer    s;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    // Full swing against the selected common darkens a pixel
    for (c = 0; c < 8; c = c + 1)
      if (com_lvl_i[2*c+:2] == 2'h3)
        for (s = 0; s < 28; s = s + 1)
          pix_o[c*28+s] <= seg_lvl_i[2*s+:2] == 2'h0;
    run <= com_lvl_i[1:0] == 2'h3 ? run + 16'h1 : 16'h0;
    if (com_lvl_i[1:0] != 2'h3 && run != 16'h0)
      slot_len_o <= run;
    // Low common beside a two-thirds neighbour marks the negative phase
    neg <= com_lvl_i[1:0] == 2'h0 && com_lvl_i[3:2] == 2'h2;
    if (com_lvl_i[1:0] == 2'h0 && com_lvl_i[3:2] == 2'h2 && !neg)
      flips_o <= flips_o + 16'h1;
  end
endmodule // sld_glass_model

// ---- sim/sld_lcd_ctrl_bench.sv ----
// Self-checking bench of the segment LCD controller with a glass model
`timescale 1ns/100ps
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, v); end end
module sld_lcd_ctrl_bench;
  reg          clk_i = 1'b0;
  reg          srst_i = 1'b1;
  reg  [7:0]   addr_i = 8'h00;
  reg  [7:0]   wdata_i = 8'h00;
  reg          wr_i = 1'b0;
  reg          rd_i = 1'b0;
  reg          low_speed_rc_osc = 1'b0;
  reg          low_speed_crystal_osc = 1'b0;
  reg          pd = 1'b0;
  reg          strap = 1'b0;
  reg          ce = 1'b1;
  wire [7:0]   rdata_o;
  wire         run_o;
  wire [15:0]  com_lvl_o;
  wire [55:0]  seg_lvl_o;
  wire [223:0] pix;
  wire [15:0]  slot_len;
  wire [15:0]  flips;
  reg  [7:0]   exp_q[$];
  reg  [7:0]   exp_r;
  reg  [7:0]   mem[0:27];
  reg  [223:0] exp_pix;
  reg  [15:0]  f0;
  reg          rd_d = 1'b0;
  integer      fail_count = 0;
  integer      tests_run = 0;
  integer      seed = 32'h45cd;
  integer      i;
  integer      j;
  integer      nc;
  always #5 clk_i = ~clk_i;
  always #40 low_speed_rc_osc = ~low_speed_rc_osc;
  always #60 low_speed_crystal_osc = ~low_speed_crystal_osc;
  sld_lcd_ctrl uut
  (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .low_speed_rc_osc_clk_i(low_speed_rc_osc), .lxt_clk_i(low_speed_crystal_osc), .powerdown_i(pd),
    .opt_pd_lcd_on_i(strap), .charge_pump_en_o(), .va_one_half_o(), .bias_r_type_o(),
    .sub_clk_run_o(run_o), .com_lvl_o(com_lvl_o), .seg_lvl_o(seg_lvl_o), .seg_pin_is_lcd_o()
  );
  sld_glass_model glass
  (
    .clk_i(clk_i), .com_lvl_i(com_lvl_o), .seg_lvl_i(seg_lvl_o), .pix_o(pix), .slot_len_o(slot_len),
    .flips_o(flips)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task wr(input [7:0] a, input [7:0] d);
  begin
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge clk_i);
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    exp_q.push_back(e);
    addr_i <= a;
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
  end
  endtask
  task idle(input integer n);
  begin
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // Read data stands only in the cycle after the read
  always @(posedge clk_i)
    rd_d <= rd_i;
  always @(negedge clk_i)
    if (rd_d)
    begin
      exp_r = exp_q.pop_front();
      `CHK("rdata", exp_r, rdata_o)
    end
  initial
  begin
    #400000;
    fail_count++;
    end_sim;
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    for (i = 0; i < 28; i = i + 1)
    begin
      mem[i] = $random(seed);
      wr(8'h40 + i[7:0], mem[i]);
    end
    for (i = 0; i < 28; i = i + 1)
      rd(8'h40 + i[7:0], mem[i]);
    rd(8'h5c, 8'h00);
    for (i = 0; i < 6; i = i + 1)
    begin
      j = $random(seed);
      // Pump taken as twice the supply, so either VA level is allowed
      wr(8'h00, j[7:0]);
      rd(8'h00, j[7:0] & 8'hd7);
      wr(8'h01, j[15:8]);
      rd(8'h01, j[15:8]);
      wr(8'h02, j[23:16]);
      rd(8'h02, j[23:16] & 8'h0f);
      wr(8'h90, j[7:0]);
      rd(8'h90, 8'h00);
    end
    wr(8'h00, 8'h00);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h02, {5'h0, i[2:0]});
      idle(1800);
      `CHK("slot", (i[1] ? 8 : 3 + i[0]) * (i[2] ? 12 : 8), slot_len)
    end
    wr(8'h02, 8'h00);
    for (i = 0; i < 8; i = i + 1)
      if (i < 5 || i == 7)
      begin
        wr(8'h00, i[7:0]);
        mem[i] = ~mem[i];
        wr(8'h40 + i[7:0], mem[i]);
        idle(500);
        nc = i[2] ? 8 : i + 4;
        for (j = 0; j < 224; j = j + 1)
          exp_pix[j] = (j / 28 < nc && j % 28 < 32 - nc) ? mem[j % 28][j / 28] : pix[j];
        `CHK("pixels", exp_pix, pix)
      end
    // Enable low: the write is dropped and the drive holds still
    ce <= 1'b0;
    wr(8'h00, 8'h80);
    f0 = com_lvl_o;
    idle(200);
    `CHK("frozen", f0, com_lvl_o)
    ce <= 1'b1;
    rd(8'h00, 8'h07);
    pd <= 1'b1;
    idle(20);
    `CHK("sub run", 1'b0, run_o)
    `CHK("commons", 16'h0, com_lvl_o)
    wr(8'h02, 8'h08);
    strap <= 1'b1;
    idle(20);
    `CHK("sub run", 1'b1, run_o)
    f0 = flips;
    idle(800);
    `CHK("flips", 1'b1, flips != f0)
    pd <= 1'b0;
    wr(8'h00, 8'h80);
    idle(5);
    `CHK("segments", 56'h0, seg_lvl_o)
    end_sim;
  end
endmodule // sld_lcd_ctrl_bench
